// ==== design/amc_ctrl.sv ====
`timescale 1ns/1ns
// Contract
// (RULE1) Done flag sets on conversion or capture end
// (RULE2) Done flag clears on vector, or by software
// (RULE3) Software sets capture bit to start capture
// (RULE4) Capture bit self-clears when capture finishes
// (RULE5) Address strobe off while capture bit set; code turns it back on once AMC_CAP is entered
// (RULE6) Continuous bit restarts conversion after each
// (RULE7) Single bit runs exactly one conversion
// (RULE8) Single bit self-clears after its conversion
// (RULE9) Software conversions use register channel field
// (RULE10) Capture conversions use channel from memory
// (RULE11) Codes 0000..0100 select inputs 0..4
// (RULE12) Codes 0101..1100 inputs 5..7 and internals
// (RULE13) Code 1111 from memory ends capture
`include "amc_map.svh"
module amc_ctrl
(
    // APB
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Converter core
    output amc_pkg::amc_conv_req_t conv_req,
    input  wire logic              conv_done,
    input  wire logic              ext_trigger,
    // Capture engine
    input  wire amc_pkg::amc_cap_id_t cap_id,
    output logic                   cap_next,
    // Core
    input  wire logic              vector_ack,
    output logic                   ale_en,
    output logic                   irq
);
    import amc_pkg::*;

    amc_state_all_t s_q;
    amc_state_all_t s_d;

    // ------------------------------------------------------------
    // Channel and register address decode
    // ------------------------------------------------------------
    function automatic logic chan_ok(input logic [3:0] code);
        chan_ok = (code <= `AMC_CH_VREF);  // [RULE11] [RULE12]
    endfunction

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
        is_addr = (a == off);
    endfunction

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = is_addr(a, `AMC_OFF_CTRL) || is_addr(a, `AMC_OFF_IRQ_STAT) ||
                  is_addr(a, `AMC_OFF_IRQ_MASK) || is_addr(a, `AMC_OFF_STATUS);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic wr;
        logic rd;
        logic acc;
        logic rise;
        logic [1:0] ev;
        acc = psel && penable && !s_q.pready;
        // Write lands on the edge that completes the transfer, not earlier
        wr = psel && penable && s_q.pready && pwrite;
        rd = acc && !pwrite;
        ev = 2'h0;
        s_d = s_q;
        s_d.req.start = 1'b0;
        s_d.cap_next = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // Trigger pin passes two flops before the edge detector reads it
        s_d.trig_sync = {s_q.trig_sync[0], ext_trigger};
        s_d.trig_prev = s_q.trig_sync[1];
        rise = s_q.trig_sync[1] & ~s_q.trig_prev;
        // Ready on second access cycle: one wait state
        if (acc)
        begin
            s_d.pready = 1'b1;
            s_d.pslverr = !reg_hit(paddr);
        end
        case (s_q.state)
            AMC_IDLE:
            begin
                if (s_q.ctrl[`AMC_BIT_CAPTURE])
                begin
                    s_d.state = AMC_CAP;
                    s_d.cap_next = 1'b1;
                end
                else if (s_q.ctrl[`AMC_BIT_SINGLE] || s_q.ctrl[`AMC_BIT_CONT] || rise)
                begin
                    s_d.state = AMC_CONV;
                    s_d.req.start = 1'b1;
                    s_d.req.channel = s_q.ctrl[3:0];  // [RULE9]
                    s_d.req.chan_valid = chan_ok(s_q.ctrl[3:0]);
                end
            end
            AMC_CONV:
            begin
                if (conv_done)
                begin
                    ev[`AMC_IRQ_DONE] = 1'b1;
                    s_d.ctrl[`AMC_BIT_DONE] = 1'b1;  // [RULE1]
                    s_d.ctrl[`AMC_BIT_SINGLE] = 1'b0;  // [RULE7] [RULE8]
                    if (s_q.ctrl[`AMC_BIT_CONT] && !s_q.ctrl[`AMC_BIT_CAPTURE])
                    begin
                        s_d.req.start = 1'b1;  // [RULE6]
                        s_d.req.channel = s_q.ctrl[3:0];
                        s_d.req.chan_valid = chan_ok(s_q.ctrl[3:0]);
                    end
                    else
                    begin
                        s_d.state = AMC_IDLE;
                    end
                end
            end
            AMC_CAP:
            begin
                if (cap_id.id_valid && cap_id.id == `AMC_CH_STOP)
                begin
                    s_d.state = AMC_IDLE;  // [RULE13]
                    s_d.ctrl[`AMC_BIT_CAPTURE] = 1'b0;  // [RULE4]
                    s_d.ctrl[`AMC_BIT_DONE] = 1'b1;  // [RULE1]
                    ev[`AMC_IRQ_CAPEND] = 1'b1;
                end
                else if (cap_id.id_valid)
                begin
                    s_d.req.start = 1'b1;
                    s_d.req.channel = cap_id.id;  // [RULE10]
                    s_d.req.chan_valid = chan_ok(cap_id.id);
                end
                else if (conv_done)
                begin
                    s_d.cap_next = 1'b1;
                end
            end
            default:
            begin
                s_d.state = AMC_IDLE;
            end
        endcase
        // Hardware clear on vectoring, unless a new set arrives
        if (vector_ack && !ev[`AMC_IRQ_DONE] && !ev[`AMC_IRQ_CAPEND])
        begin
            s_d.ctrl[`AMC_BIT_DONE] = 1'b0;  // [RULE2]
        end
        if (wr)
        begin
            if (is_addr(paddr, `AMC_OFF_CTRL))
            begin
                // Done flag: software may only clear; hardware set wins
                s_d.ctrl[6:0] = pwdata[6:0];  // [RULE3]
                if (s_q.state == AMC_CAP && !pwdata[`AMC_BIT_CAPTURE])
                begin
                    s_d.state = AMC_IDLE;
                end
                if (!pwdata[`AMC_BIT_DONE] && !ev[`AMC_IRQ_DONE] && !ev[`AMC_IRQ_CAPEND])
                begin
                    s_d.ctrl[`AMC_BIT_DONE] = 1'b0;  // [RULE2]
                end
            end
            else if (is_addr(paddr, `AMC_OFF_IRQ_STAT))
            begin
                s_d.irq_stat = s_q.irq_stat & ~pwdata[1:0];
            end
            else if (is_addr(paddr, `AMC_OFF_IRQ_MASK))
            begin
                s_d.irq_mask = pwdata[1:0];
            end
        end
        s_d.irq_stat = s_d.irq_stat | ev;
        // Unmapped reads return zero; the error flag is raised above
        if (rd)
        begin
            s_d.prdata = 32'h0;
            if (is_addr(paddr, `AMC_OFF_CTRL))
            begin
                s_d.prdata[7:0] = s_q.ctrl;
            end
            else if (is_addr(paddr, `AMC_OFF_IRQ_STAT))
            begin
                s_d.prdata[1:0] = s_q.irq_stat;
            end
            else if (is_addr(paddr, `AMC_OFF_IRQ_MASK))
            begin
                s_d.prdata[1:0] = s_q.irq_mask;
            end
            else if (is_addr(paddr, `AMC_OFF_STATUS))
            begin
                s_d.prdata[1:0] = s_q.state;
            end
        end
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
        // Strobe paused while capture is armed, back once capture runs
        s_d.ale_en = !(s_d.ctrl[`AMC_BIT_CAPTURE] && s_d.state != AMC_CAP);  // [RULE5]
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '{state: AMC_IDLE, ctrl: `AMC_CTRL_RESET, irq_stat: `AMC_IRQ_RESET,
                     irq_mask: 2'h0, irq: 1'b0, ale_en: 1'b1, cap_next: 1'b0,
                     req: '0, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0,
                     trig_sync: 2'h0, trig_prev: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata   = s_q.prdata;
    assign pready   = s_q.pready;
    assign pslverr  = s_q.pslverr;
    assign conv_req = s_q.req;
    assign cap_next = s_q.cap_next;
    assign ale_en   = s_q.ale_en;
    assign irq      = s_q.irq;

endmodule

// ==== design/amc_map.svh ====
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define AMC_OFF_CTRL     12'h000
`define AMC_OFF_IRQ_STAT 12'h004
`define AMC_OFF_IRQ_MASK 12'h008
`define AMC_OFF_STATUS   12'h00c

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define AMC_BIT_DONE     7
`define AMC_BIT_CAPTURE  6
`define AMC_BIT_CONT     5
`define AMC_BIT_SINGLE   4
`define AMC_CTRL_RESET   8'h00

// ------------------------------------------------------------
// Channel codes
// ------------------------------------------------------------
`define AMC_CH_TEMP      4'h8
`define AMC_CH_OUT0      4'h9
`define AMC_CH_OUT1      4'ha
`define AMC_CH_AGND      4'hb
`define AMC_CH_VREF      4'hc
`define AMC_CH_STOP      4'hf

// ------------------------------------------------------------
// Interrupt status bits
// ------------------------------------------------------------
`define AMC_IRQ_DONE     0
`define AMC_IRQ_CAPEND   1
`define AMC_IRQ_RESET    2'h0

`endif

// ==== design/amc_pkg.sv ====
package amc_pkg;

    typedef enum logic [1:0]
    {
        AMC_IDLE = 2'b00,
        AMC_CONV = 2'b01,
        AMC_CAP  = 2'b10
    } amc_state_t;

    // Request to the converter core
    typedef struct packed
    {
        logic       start;
        logic [3:0] channel;
        logic       chan_valid;
    } amc_conv_req_t;

    // Capture engine handshake
    typedef struct packed
    {
        logic       id_valid;
        logic [3:0] id;
    } amc_cap_id_t;

    typedef struct packed
    {
        amc_state_t    state;
        logic [7:0]    ctrl;
        logic [1:0]    irq_stat;
        logic [1:0]    irq_mask;
        logic          irq;
        logic          ale_en;
        logic          cap_next;
        amc_conv_req_t req;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        logic [1:0]    trig_sync;
        logic          trig_prev;
    } amc_state_all_t;

endpackage

// ==== testbench/amc_ctrl_assertions.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module amc_ctrl_assertions
(
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // APB
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pready,
    // Converter and capture
    input wire amc_pkg::amc_conv_req_t conv_req,
    input wire logic                   conv_done,
    input wire amc_pkg::amc_cap_id_t   cap_id,
    input wire logic                   cap_next,
    input wire logic                   ale_en
);
    import amc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic in_cap_q;
    // Capture in progress, tracked from the engine handshake alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_cap_q <= 1'b0;
        end
        else if (cap_next)
        begin
            in_cap_q <= 1'b1;
        end
        else if (cap_id.id_valid && cap_id.id == 4'hf)
        begin
            in_cap_q <= 1'b0;
        end
    end
    property p_ready; psel && penable && !pready |=> pready; endproperty
    property p_ale; cap_next |-> ale_en; endproperty
    property p_chv; conv_req.start |-> conv_req.chan_valid == (conv_req.channel <= 4'hc); endproperty
    property p_capch; in_cap_q && cap_id.id_valid && cap_id.id != 4'hf
        |=> conv_req.start && conv_req.channel == $past(cap_id.id); endproperty
    property p_capnext; in_cap_q && conv_done |-> ##[1:2] cap_next; endproperty
    property p_stop; in_cap_q && cap_id.id_valid && cap_id.id == 4'hf |=> !conv_req.start [*3]; endproperty
    property p_end; in_cap_q && cap_id.id_valid && cap_id.id == 4'hf |=> !cap_next [*3]; endproperty
    property p_pulse; conv_req.start |=> !conv_req.start; endproperty
    a_ready: assert property (p_ready) else $error("apb answer late");
    a_ale: assert property (p_ale) else $error("strobe off while capture runs");
    a_chv: assert property (p_chv) else $error("channel valid wrong");
    a_capch: assert property (p_capch) else $error("capture channel wrong");
    a_capnext: assert property (p_capnext) else $error("no next id request");
    a_stop: assert property (p_stop) else $error("conversion after stop code");
    a_end: assert property (p_end) else $error("capture did not end");
    a_pulse: assert property (p_pulse) else $error("start not a pulse");
    c_single: cover property (conv_req.start && !in_cap_q);
    c_cap: cover property (cap_next);
    c_stop: cover property (cap_id.id_valid && cap_id.id == 4'hf);
endmodule

// ==== testbench/amc_ctrl_test.sv ====
`timescale 1ns/1ns
`include "amc_map.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module amc_ctrl_test;
    import amc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]   paddr = 0;
    logic [31:0]   pwdata = 0, prdata, rdat;
    logic          pready, pslverr, cap_next, ale_en, irq, rerr;
    logic          conv_done = 0, ext_trigger = 0, vector_ack = 0;
    amc_conv_req_t conv_req;
    amc_cap_id_t   cap_id = '0;
    logic [7:0]    rnd = 8'h28;
    int            n_errors = 0, checks_done = 0, nstart = 0, ns0;
    always #5 pclk = ~pclk;
    // Counts every start so single mode can be held to one
    always @(posedge pclk) if (conv_req.start === 1'b1) nstart++;
    amc_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .conv_req, .conv_done, .ext_trigger, .cap_id, .cap_next, .vector_ack, .ale_en, .irq);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic exp_valid(input logic [3:0] c);
        return c <= 4'hc;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic vec);
        @(posedge pclk);
        if (vec) vector_ack <= 1'b1;
        else conv_done <= 1'b1;
        @(posedge pclk);
        conv_done <= 1'b0;
        vector_ack <= 1'b0;
    endtask
    // Bounded wait; a lost pulse must not hang the run
    task automatic wt(input logic cap);
        int k;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (!(cap ? cap_next === 1'b1 : conv_req.start === 1'b1) && k < 40);
        `CHK(k < 40, 1'b1)
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_errors++;
        final_report;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 5; a++)
        begin
            apb(1'b0, 12'(a * 4), 32'h0);
            `CHK(rdat, 32'h0)
            `CHK(rerr, a == 4)
        end
        `CHK(ale_en, 1'b1)
        $display("test reset done");
        apb(1'b1, `AMC_OFF_IRQ_MASK, 32'h3);
        for (int c = 0; c < 16; c++)
        begin
            ns0 = nstart;
            apb(1'b1, `AMC_OFF_CTRL, 32'h10 | 32'(c));
            wt(1'b0);
            `CHK(conv_req.channel, 4'(c))
            `CHK(conv_req.chan_valid, exp_valid(4'(c)))
            pulse(1'b0);
            apb(1'b0, `AMC_OFF_CTRL, 32'h0);
            `CHK(rdat, 32'h80 | 32'(c))
            `CHK(irq, 1'b1)
            pulse(1'b1);
            apb(1'b1, `AMC_OFF_IRQ_STAT, 32'h1);
            apb(1'b0, `AMC_OFF_CTRL, 32'h0);
            `CHK(rdat, 32'(c))
            `CHK(irq, 1'b0)
            `CHK(nstart - ns0, 1)
        end
        $display("test single done");
        rnd = lfsr(rnd);
        apb(1'b1, `AMC_OFF_CTRL, 32'h20 | 32'(rnd[2:0]));
        repeat (rnd[5:4] + 2)
        begin
            wt(1'b0);
            `CHK(conv_req.channel, {1'b0, rnd[2:0]})
            pulse(1'b0);
        end
        apb(1'b1, `AMC_OFF_CTRL, 32'h0);
        pulse(1'b0);
        $display("test continuous done");
        rnd = lfsr(rnd);
        apb(1'b1, `AMC_OFF_CTRL, 32'(rnd[3:0]));
        ext_trigger <= 1'b1;
        wt(1'b0);
        `CHK(conv_req.channel, rnd[3:0])
        ext_trigger <= 1'b0;
        pulse(1'b0);
        $display("test trigger done");
        apb(1'b1, `AMC_OFF_IRQ_STAT, 32'h3);
        apb(1'b1, `AMC_OFF_CTRL, 32'h40);
        @(posedge pclk);
        `CHK(ale_en, 1'b0)
        wt(1'b1);
        `CHK(ale_en, 1'b1)
        rnd = lfsr(rnd);
        cap_id <= {1'b1, rnd[3:0] % 4'hf};
        @(posedge pclk);
        cap_id <= '0;
        wt(1'b0);
        `CHK(conv_req.channel, rnd[3:0] % 4'hf)
        pulse(1'b0);
        wt(1'b1);
        cap_id <= {1'b1, `AMC_CH_STOP};
        @(posedge pclk);
        cap_id <= '0;
        apb(1'b0, `AMC_OFF_CTRL, 32'h0);
        `CHK(rdat[7:6], 2'b10)
        `CHK(ale_en, 1'b1)
        apb(1'b0, `AMC_OFF_IRQ_STAT, 32'h0);
        `CHK(rdat[1], 1'b1)
        $display("test capture done");
        final_report;
    end
endmodule
bind amc_ctrl amc_ctrl_assertions u_chk (.pclk, .presetn, .psel, .penable, .pready, .conv_req,
    .conv_done, .cap_id, .cap_next, .ale_en);
